// >>> include/result_bank_pkg.sv
/*
  Package for the measurement result bank: register offsets, control field positions, reset values,
  channel codes and the record carried from the converter into the bank.
  Assumes an 8-bit register address space reached by a byte-wide register port.
*/
package result_bank_pkg;

  localparam logic [7:0] OFF_CONTROL          = 8'h2e;
  localparam logic [7:0] OFF_DISABLE_0        = 8'h2f;
  localparam logic [7:0] OFF_DISABLE_1        = 8'h30;
  localparam logic [7:0] OFF_INPUT_CURRENT    = 8'h31;
  localparam logic [7:0] OFF_BATTERY_CURRENT  = 8'h33;
  localparam logic [7:0] OFF_BUS_VOLTAGE      = 8'h35;
  localparam logic [7:0] OFF_ADAPTER_ONE      = 8'h37;
  localparam logic [7:0] OFF_ADAPTER_TWO      = 8'h39;
  localparam logic [7:0] OFF_BATTERY_VOLTAGE  = 8'h3b;
  localparam logic [7:0] OFF_SYSTEM_VOLTAGE   = 8'h3d;

  localparam int CTL_ENABLE_BIT     = 7;
  localparam int CTL_ONE_SHOT_BIT   = 6;
  localparam int CTL_SPEED_LSB      = 4;
  localparam int CTL_AVERAGE_BIT    = 3;
  localparam int CTL_SEED_BIT       = 2;

  localparam logic [7:0] CONTROL_RESET   = 8'h30;
  localparam logic [7:0] DISABLE_0_RESET = 8'h00;
  localparam logic [7:0] DISABLE_1_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET   = 16'h0000;

  localparam logic [7:0] DISABLE_0_MASK = 8'hfe;
  localparam logic [7:0] DISABLE_1_MASK = 8'hf0;

  localparam int MAX_INPUT_CURRENT_MA   = 5000;
  localparam int MAX_BATTERY_CURRENT_MA = 8000;
  localparam int MAX_BUS_VOLTAGE_MV     = 30000;
  localparam int MAX_BATTERY_VOLTAGE_MV = 20000;
  localparam int MAX_SYSTEM_VOLTAGE_MV  = 24000;

  localparam int NUM_CHANNELS = 7;

  typedef enum logic [2:0] {
    CH_INPUT_CURRENT   = 3'b000,
    CH_BATTERY_CURRENT = 3'b001,
    CH_BUS_VOLTAGE     = 3'b010,
    CH_ADAPTER_ONE     = 3'b011,
    CH_ADAPTER_TWO     = 3'b100,
    CH_BATTERY_VOLTAGE = 3'b101,
    CH_SYSTEM_VOLTAGE  = 3'b110
  } channel_t;

  typedef struct packed {
    logic        valid;
    channel_t    channel;
    logic [15:0] value;
  } sample_t;

endpackage

// >>> hdl/result_bank.sv
/*
  Measurement result bank with its converter control: sequences channels, averages, clamps and
  stores 16-bit signed results, and serves byte reads and writes at the register port.
  Assumes the analog converter answers each request with one sample_t pulse on the same clock,
  and the serial host logic presents one byte access per cycle.
*/
// Notes on behaviour
// - Input current is signed; positive flows from bus input toward middle node.
// - Input current is one milliampere per bit, zero offset, magnitude up to 5000.
// - Battery current is signed: positive while charging, negative while discharging.
// - Battery current is one milliampere per bit, zero offset, magnitude up to 8000.
// - Bus and both adapter voltages: signed, one millivolt per bit, up to 30000.
// - Battery voltage is positive minus negative sense, one millivolt per bit, up to 20000.
// - System voltage is signed, zero offset, up to 24000 millivolts.
// - Converter runs only when enabled; continuous or one shot per request.
// - Two-bit speed code selects 15, 14, 13 or 12 bits; reset code is 3.
// - Averaging bit picks single or running average; seed bit picks old or fresh start.
// - Each channel has a disable bit, clear at reset; set excludes the channel.
`timescale 1ns/1ps
module result_bank (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     reg_sel,
  input  wire logic                     reg_write,
  input  wire logic                     reg_last,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  output logic                          conv_request,
  output result_bank_pkg::channel_t     conv_channel,
  output logic      [3:0]               conv_bits,
  input  wire result_bank_pkg::sample_t conv_sample,
  output logic                          conv_busy
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PICK = 2'b01,
    ST_WAIT = 2'b10
  } seq_t;

  logic [7:0]  control_ff;
  logic [7:0]  disable0_ff;
  logic [7:0]  disable1_ff;
  logic [15:0] result_ff [result_bank_pkg::NUM_CHANNELS];
  logic [6:0]  seeded_ff;
  seq_t        state_ff;
  seq_t        nxt_state;
  logic [2:0]  chan_ff;
  logic [2:0]  nxt_chan;
  logic        shot_ff;
  logic [7:0]  low_latch_ff;
  logic        pair_hold_ff;
  logic [6:0]  chan_off;
  logic        enabled;
  logic        one_shot;
  logic        write_ctl;
  logic [15:0] clamped;
  logic [15:0] averaged;
  logic        accept;
  logic        pass_done;
  logic [7:0]  pair_addr_ff;
  logic [15:0] old_word;

  // Clamps a signed reading to the channel's full-scale magnitude.
  function automatic logic [15:0] clamp_signed(input logic [15:0] v, input int limit);
    logic signed [16:0] s;
    logic signed [16:0] lim;
    s   = {v[15], v};
    lim = 17'(limit);
    if (s > lim) begin
      clamp_signed = lim[15:0];
    end else if (s < -lim) begin
      clamp_signed = 16'((-lim));
    end else begin
      clamp_signed = v;
    end
  endfunction

  // Maps a channel code to its full-scale figure.
  function automatic int channel_limit(input logic [2:0] ch);
    case (ch)
      3'h0:    channel_limit = result_bank_pkg::MAX_INPUT_CURRENT_MA;
      3'h1:    channel_limit = result_bank_pkg::MAX_BATTERY_CURRENT_MA;
      3'h5:    channel_limit = result_bank_pkg::MAX_BATTERY_VOLTAGE_MV;
      3'h6:    channel_limit = result_bank_pkg::MAX_SYSTEM_VOLTAGE_MV;
      default: channel_limit = result_bank_pkg::MAX_BUS_VOLTAGE_MV;
    endcase
  endfunction

  // Maps either byte offset of a result register to its channel; 3'h7 means no result there.
  function automatic logic [2:0] offset_channel(input logic [7:0] a);
    case (a)
      result_bank_pkg::OFF_INPUT_CURRENT,   8'h32: offset_channel = 3'h0;
      result_bank_pkg::OFF_BATTERY_CURRENT, 8'h34: offset_channel = 3'h1;
      result_bank_pkg::OFF_BUS_VOLTAGE,     8'h36: offset_channel = 3'h2;
      result_bank_pkg::OFF_ADAPTER_ONE,     8'h38: offset_channel = 3'h3;
      result_bank_pkg::OFF_ADAPTER_TWO,     8'h3a: offset_channel = 3'h4;
      result_bank_pkg::OFF_BATTERY_VOLTAGE, 8'h3c: offset_channel = 3'h5;
      result_bank_pkg::OFF_SYSTEM_VOLTAGE,  8'h3e: offset_channel = 3'h6;
      default:                                     offset_channel = 3'h7;
    endcase
  endfunction

  assign enabled   = control_ff[result_bank_pkg::CTL_ENABLE_BIT];
  assign one_shot  = control_ff[result_bank_pkg::CTL_ONE_SHOT_BIT];
  assign write_ctl = reg_sel && reg_write && (reg_addr == result_bank_pkg::OFF_CONTROL);
  assign accept    = conv_request && conv_sample.valid && (conv_sample.channel == conv_channel);

  // A pass ends on any step back to idle, also one whose last channels are disabled.
  assign pass_done = (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);

  // Channel order follows channel_t: input current, battery current, bus, adapter one, two, battery, system.
  assign chan_off = {disable0_ff[3], disable0_ff[4], disable1_ff[5], disable1_ff[4],
                     disable0_ff[5], disable0_ff[6], disable0_ff[7]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_ff  <= result_bank_pkg::CONTROL_RESET;
      disable0_ff <= result_bank_pkg::DISABLE_0_RESET;
      disable1_ff <= result_bank_pkg::DISABLE_1_RESET;
    end else if (reg_sel && reg_write) begin
      case (reg_addr)
        result_bank_pkg::OFF_CONTROL:   control_ff  <= reg_wdata;
        result_bank_pkg::OFF_DISABLE_0: disable0_ff <= reg_wdata & result_bank_pkg::DISABLE_0_MASK;
        result_bank_pkg::OFF_DISABLE_1: disable1_ff <= reg_wdata & result_bank_pkg::DISABLE_1_MASK;
        default: ;
      endcase
    end else if (one_shot && pass_done) begin
      // A finished one-shot pass drops the enable bit, so the next pass needs a new request.
      control_ff[result_bank_pkg::CTL_ENABLE_BIT] <= 1'b0;
    end
  end

  // Walks enabled channels in order; one shot runs one pass per enable write.
  always_comb begin
    nxt_state = state_ff;
    nxt_chan  = chan_ff;
    case (state_ff)
      ST_IDLE: begin
        if (enabled && (!one_shot || shot_ff)) begin
          nxt_state = ST_PICK;
          nxt_chan  = 3'h0;
        end
      end
      ST_PICK: begin
        if (!enabled) begin
          nxt_state = ST_IDLE;
        end else if (chan_ff == 3'(result_bank_pkg::NUM_CHANNELS)) begin
          nxt_state = one_shot ? ST_IDLE : ST_PICK;
          nxt_chan  = 3'h0;
        end else if (chan_off[chan_ff]) begin
          nxt_chan = chan_ff + 3'h1;
        end else begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // A sample for another channel is refused, so it neither stores nor advances.
        if (accept) begin
          nxt_chan  = chan_ff + 3'h1;
          nxt_state = (one_shot && chan_ff == 3'(result_bank_pkg::NUM_CHANNELS - 1)) ? ST_IDLE : ST_PICK;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_chan  = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      chan_ff  <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      chan_ff  <= nxt_chan;
    end
  end

  // A one-shot request is armed by writing the enable bit and spent by starting a pass.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shot_ff <= 1'b0;
    end else if (write_ctl) begin
      shot_ff <= reg_wdata[result_bank_pkg::CTL_ENABLE_BIT];
    end else if (state_ff == ST_IDLE && nxt_state == ST_PICK) begin
      shot_ff <= 1'b0;
    end
  end

  assign conv_request = (state_ff == ST_WAIT);
  assign conv_channel = result_bank_pkg::channel_t'(chan_ff);
  assign conv_bits    = 4'hf - {2'b00, control_ff[result_bank_pkg::CTL_SPEED_LSB +: 2]};
  assign conv_busy    = (state_ff != ST_IDLE);

  // Sign is kept as delivered, so current direction survives into the result.
  assign clamped = clamp_signed(conv_sample.value, channel_limit(chan_ff));

  // Half-sum running average; an arithmetic shift keeps negative currents negative.
  assign averaged = 16'(($signed({old_word[15], old_word})
                       + $signed({clamped[15], clamped})) >>> 1);

  // Channel code 7 marks the end of a pass and has no word, so it reads as zero.
  always_comb begin
    old_word = result_bank_pkg::RESULT_RESET;
    if (chan_ff != 3'h7) begin
      old_word = result_ff[chan_ff];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < result_bank_pkg::NUM_CHANNELS; i++) begin
        result_ff[i] <= result_bank_pkg::RESULT_RESET;
      end
      seeded_ff <= 7'h00;
    end else begin
      if (write_ctl) begin
        seeded_ff <= 7'h00;
      end
      if (accept) begin
        // Whole word written in one edge, never byte by byte.
        if (!control_ff[result_bank_pkg::CTL_AVERAGE_BIT]) begin
          result_ff[chan_ff] <= clamped;
        end else if (control_ff[result_bank_pkg::CTL_SEED_BIT] && !seeded_ff[chan_ff]) begin
          result_ff[chan_ff] <= clamped;
        end else begin
          result_ff[chan_ff] <= averaged;
        end
        seeded_ff[chan_ff] <= 1'b1;
      end
    end
  end

  // Reading a high byte latches the low byte, so the pair comes from one conversion.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_latch_ff <= 8'h00;
      pair_hold_ff <= 1'b0;
      pair_addr_ff <= 8'h00;
    end else if (reg_sel && !reg_write) begin
      if (offset_channel(reg_addr) != 3'h7 && reg_addr[0]) begin
        low_latch_ff <= result_ff[offset_channel(reg_addr)][7:0];
        pair_hold_ff <= !reg_last;
        pair_addr_ff <= reg_addr + 8'h01;
      end else begin
        pair_hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_sel && !reg_write) begin
      case (reg_addr)
        result_bank_pkg::OFF_CONTROL:   reg_rdata <= {control_ff[7:2], 2'b00};
        result_bank_pkg::OFF_DISABLE_0: reg_rdata <= disable0_ff;
        result_bank_pkg::OFF_DISABLE_1: reg_rdata <= disable1_ff;
        default: begin
          if (offset_channel(reg_addr) == 3'h7) begin
            reg_rdata <= 8'h00;
          end else if (reg_addr[0]) begin
            reg_rdata <= result_ff[offset_channel(reg_addr)][15:8];
          end else if (pair_hold_ff && reg_addr == pair_addr_ff) begin
            // The latched byte only answers its partner address; a jump elsewhere reads live data.
            reg_rdata <= low_latch_ff;
          end else begin
            reg_rdata <= result_ff[offset_channel(reg_addr)][7:0];
          end
        end
      endcase
    end
  end

endmodule // result_bank

// >>> verif/result_bank_sva.sv
/* Port checker for the result bank.
   Assumes it is bound to result_bank and sees only its ports. */
`timescale 1ns/1ps
module result_bank_sva (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      reg_sel,
  input wire logic                      reg_write,
  input wire logic                      reg_last,
  input wire logic [7:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      conv_request,
  input wire result_bank_pkg::channel_t conv_channel,
  input wire logic [3:0]                conv_bits,
  input wire result_bank_pkg::sample_t  conv_sample,
  input wire logic                      conv_busy
);
  logic                      acc;
  logic                      seen_ff;
  result_bank_pkg::channel_t last_ff;
  assign acc = conv_request && conv_sample.valid && conv_sample.channel == conv_channel;
  always_ff @(posedge clk) begin
    if (!rst_n) seen_ff <= 1'b0;
    else if (acc) seen_ff <= 1'b1;
    else if (!conv_busy) seen_ff <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (acc) last_ff <= conv_channel;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctl_wr; reg_sel && reg_write && reg_addr == 8'h2e && !reg_wdata[6]; endsequence
  sequence s_ctl_rd; reg_sel && !reg_write && reg_addr == 8'h2e; endsequence
  property p_reset; $rose(rst_n) |-> reg_rdata == 8'h00 && !conv_busy && !conv_request && conv_bits == 4'd12;
  endproperty
  property p_req_busy; conv_request |-> conv_busy; endproperty
  property p_req_hold; conv_request && !acc |=> conv_request && $stable(conv_channel); endproperty
  property p_gap; acc |=> !conv_request; endproperty
  property p_order; $rose(conv_request) && seen_ff && last_ff != result_bank_pkg::CH_SYSTEM_VOLTAGE
    |-> conv_channel > last_ff; endproperty
  property p_bits; logic [1:0] c; (s_ctl_wr, c = reg_wdata[5:4]) |=> conv_bits == 4'd15 - {2'b00, c}; endproperty
  property p_ctl_rb; s_ctl_wr ##2 s_ctl_rd |=> reg_rdata == ($past(reg_wdata, 3) & 8'hfc); endproperty
  property p_dis1; reg_sel && !reg_write && reg_addr == 8'h30 |=> reg_rdata[3:0] == 4'h0; endproperty
  property p_hold; !(reg_sel && !reg_write) |=> $stable(reg_rdata); endproperty
  a_reset: assert property (p_reset) else $error("bad values after reset");
  a_req_busy: assert property (p_req_busy) else $error("request while idle");
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  a_gap: assert property (p_gap) else $error("request not dropped after sample");
  a_order: assert property (p_order) else $error("channel order broken");
  a_bits: assert property (p_bits) else $error("resolution mismatch");
  a_ctl_rb: assert property (p_ctl_rb) else $error("control readback wrong");
  a_dis1: assert property (p_dis1) else $error("reserved disable bits set");
  a_hold: assert property (p_hold) else $error("read data changed");
endmodule // result_bank_sva
bind result_bank result_bank_sva chk_u (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_write(reg_write),
  .reg_last(reg_last), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .conv_request(conv_request), .conv_channel(conv_channel), .conv_bits(conv_bits),
  .conv_sample(conv_sample), .conv_busy(conv_busy));

// >>> verif/conv_model.sv
/* Behavioural converter answering the result bank's requests.
   Assumes one request at a time; slow adds three cycles of latency. */
`timescale 1ns/1ps
module conv_model (
  input wire logic                      clk,
  input wire logic                      slow,
  input wire logic                      conv_request,
  input wire result_bank_pkg::channel_t conv_channel,
  input wire logic [6:0][15:0]          vals,
  output result_bank_pkg::sample_t      conv_sample
);
  logic [1:0] wait_q;
  initial wait_q = 2'd0;
  initial conv_sample = '0;
  always @(posedge clk) begin
    conv_sample.valid <= 1'b0;
    // Idle value toggles so a stale word is never mistaken for a fresh one.
    conv_sample.value <= ~conv_sample.value;
    if (!conv_request || conv_sample.valid) wait_q <= 2'd0;
    else if (wait_q == (slow ? 2'd3 : 2'd0)) begin
      conv_sample <= {1'b1, conv_channel, vals[conv_channel]};
      wait_q <= 2'd0;
    end
    else wait_q <= wait_q + 2'd1;
  end
endmodule // conv_model

// >>> verif/tb_result_bank.sv
/* Self-checking bench for the result bank.
   Assumes the converter model stands on the far side. */
`timescale 1ns/1ps
module tb_result_bank;
  logic clk, rst_n, reg_sel, reg_write, reg_last, slow, conv_request, conv_busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] conv_bits;
  logic [15:0] w;
  logic [6:0][15:0] vals;
  result_bank_pkg::channel_t conv_channel;
  result_bank_pkg::sample_t conv_sample;
  int error_cnt, cmp_count;
  int mx[7] = '{5000, 8000, 30000, 30000, 30000, 20000, 24000};
  int v1[7] = '{-1234, 9000, 30000, 12000, -5, 25000, -30000};
  int v2[7] = '{-1000, 2000, 7, 2000, 9, 10000, 0};
  int ex[7];
  result_bank dut_u (.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_write(reg_write), .reg_last(reg_last),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_request(conv_request),
    .conv_channel(conv_channel), .conv_bits(conv_bits), .conv_sample(conv_sample), .conv_busy(conv_busy));
  conv_model model_u (.clk(clk), .slow(slow), .conv_request(conv_request), .conv_channel(conv_channel),
    .vals(vals), .conv_sample(conv_sample));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); reg_sel <= 1'b1; reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk); reg_sel <= 1'b0;
  endtask
  task rd8(input logic [7:0] a);
    @(posedge clk); reg_sel <= 1'b1; reg_write <= 1'b0; reg_addr <= a; reg_last <= 1'b1;
    @(posedge clk); reg_sel <= 1'b0;
    #1 w = {8'h00, reg_rdata};
  endtask
  // The low byte is read in the very next cycle so both halves come from one word.
  task rd16(input logic [7:0] a);
    @(posedge clk); reg_sel <= 1'b1; reg_write <= 1'b0; reg_addr <= a; reg_last <= 1'b0;
    @(posedge clk); reg_addr <= a + 8'h01; reg_last <= 1'b1;
    #1 w[15:8] = reg_rdata;
    @(posedge clk); reg_sel <= 1'b0;
    #1 w[7:0] = reg_rdata;
  endtask
  task idle;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    #1 while (conv_busy !== 1'b0 && n < 500) begin
      @(posedge clk);
      #1 n++;
    end
    chk({15'h0, conv_busy}, 16'h0000);
  endtask
  function int clampv(int v, int m);
    return v > m ? m : (v < -m ? -m : v);
  endfunction
  task tally_and_finish;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    rst_n = 0; reg_sel = 0; reg_write = 0; reg_last = 0; reg_addr = 0; reg_wdata = 0; slow = 1;
    error_cnt = 0; cmp_count = 0;
    for (int i = 0; i < 7; i++) vals[i] = 16'(v1[i]);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd8(8'h2e); chk(w, 16'h0030);
    rd8(8'h2f); chk(w, 16'h0000);
    rd8(8'h30); chk(w, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      rd16(8'(8'h31 + 2 * i)); chk(w, 16'h0000);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h2e, 8'(c << 4));
      #1 chk({12'h0, conv_bits}, 16'(15 - c));
    end
    wr(8'h2e, 8'h3f); rd8(8'h2e); chk(w, 16'h003c);
    wr(8'h2e, 8'hc0); idle;
    rd8(8'h2e); chk(w, 16'h0040);
    for (int i = 0; i < 7; i++) begin
      ex[i] = clampv(v1[i], mx[i]);
      rd16(8'(8'h31 + 2 * i)); chk(w, 16'(ex[i]));
    end
    wr(8'h2f, 8'h20); wr(8'h30, 8'h20);
    rd8(8'h2f); chk(w, 16'h0020);
    for (int i = 0; i < 7; i++) vals[i] <= 16'(v2[i]);
    slow <= 1'b0;
    wr(8'h2e, 8'hc8); idle;
    for (int i = 0; i < 7; i++) begin
      if (i != 2 && i != 4) ex[i] = (ex[i] + v2[i]) >>> 1;
      rd16(8'(8'h31 + 2 * i)); chk(w, 16'(ex[i]));
    end
    wr(8'h2e, 8'hcc); idle;
    for (int i = 0; i < 7; i++) begin
      if (i != 2 && i != 4) ex[i] = v2[i];
      rd16(8'(8'h31 + 2 * i)); chk(w, 16'(ex[i]));
    end
    wr(8'h2e, 8'h80);
    repeat (100) @(posedge clk);
    #1 chk({15'h0, conv_busy}, 16'h0001);
    wr(8'h2e, 8'h00); idle;
    wr(8'h31, 8'haa);
    rd16(8'h31); chk(w, 16'(v2[0]));
    rd8(8'h80); chk(w, 16'h0000);
    tally_and_finish;
  end
endmodule // tb_result_bank
